// File: rtl/sacint_pkg.sv
// constants shared by the serial attenuator control block
`default_nettype none
package sacint_pkg;
	localparam int FRAME_BITS            = 16;
	localparam int BYTE_BITS             = 8;
	localparam int CHANNELS              = 3;
	localparam logic [7:0] ADDR_CH1      = 8'h00;
	localparam logic [7:0] ADDR_CH2      = 8'h01;
	localparam logic [7:0] ADDR_CH3      = 8'h02;
	localparam logic [7:0] CODE_MUTE_MIN = 8'h4F;
	localparam logic [7:0] CODE_FINE_MAX = 8'h1F;
	localparam logic [7:0] CODE_MID_MAX  = 8'h3F;
	localparam logic [7:0] CODE_MUTE     = 8'hFF;
	localparam logic [7:0] RESET_CODE    = 8'hFF;
	localparam logic [9:0] RESET_HALFDB  = 10'h3FF;
endpackage
`default_nettype wire

// File: rtl/sacint_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module sacint_sync #(
	parameter logic RESET_VAL = 1'b0
) (
	input  wire logic ref_clk,
	input  wire logic reset_n,
	input  wire logic pin_in,
	output var  logic pin_sync
);
	logic meta_q;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_q   <= RESET_VAL;
			pin_sync <= RESET_VAL;
		end else begin
			meta_q   <= pin_in;
			pin_sync <= meta_q;
		end
	end
endmodule
`default_nettype wire

// File: rtl/sacint_top.sv
// three-channel attenuator serial control: shift register, latch and decode
// How it works
// - both bytes travel most significant bit first
// - old register contents leave on the chain output, one bit per clock
// - load/shift rising latches frame and selects the addressed channel's tap
// - unrecognised address bytes change nothing
// - only the addressed channel updates; others keep their setting
// - address 0, 1, 2 select channels one, two, three
// - codes 0-31 half dB, 32-63 one dB, 64-78 two dB steps
// - codes 79 to 255 mute the addressed channel
// - every channel is muted after reset until it is addressed
// - data sampled on rising serial clock only while load/shift is low
`timescale 1ns/1ps
`default_nettype none
module sacint_top (
	input  wire logic        ref_clk,
	input  wire logic        reset_n,
	input  wire logic        sclk,
	input  wire logic        load_shift,
	input  wire logic        data_in,
	output var  logic        data_out,
	output var  logic [7:0]  ch1_code,
	output var  logic [7:0]  ch2_code,
	output var  logic [7:0]  ch3_code,
	output var  logic [2:0]  ch_mute,
	output var  logic [9:0]  ch1_halfdb,
	output var  logic [9:0]  ch2_halfdb,
	output var  logic [9:0]  ch3_halfdb,
	output var  logic        frame_taken
);
	logic        sclk_s;
	logic        ls_s;
	logic        din_s;
	logic        sclk_prev_q;
	logic        ls_prev_q;
	logic [15:0] shift_q;
	logic        sclk_rise;
	logic        ls_rise;
	logic [7:0]  addr_w;
	logic [7:0]  code_w;

	sacint_sync #(.RESET_VAL(1'b0)) u_sync_clk (
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.pin_in  (sclk),
		.pin_sync(sclk_s)
	);
	// enable idles high so a reset during idle sees no false edge
	sacint_sync #(.RESET_VAL(1'b1)) u_sync_ls (
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.pin_in  (load_shift),
		.pin_sync(ls_s)
	);
	sacint_sync #(.RESET_VAL(1'b0)) u_sync_din (
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.pin_in  (data_in),
		.pin_sync(din_s)
	);

	// attenuation in half-dB units, all-ones marks mute
	function automatic logic [9:0] code_to_halfdb(input logic [7:0] code);
		logic [9:0] c;
		c = {2'b00, code};
		if (code >= sacint_pkg::CODE_MUTE_MIN)
			code_to_halfdb = sacint_pkg::RESET_HALFDB;
		else if (code <= sacint_pkg::CODE_FINE_MAX)
			code_to_halfdb = c;
		else if (code <= sacint_pkg::CODE_MID_MAX)
			code_to_halfdb = 10'(c + c - 10'h020);
		else
			code_to_halfdb = 10'(c * 10'h004 - 10'h0A0);
	endfunction

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			sclk_prev_q <= 1'b0;
			ls_prev_q   <= 1'b1;
		end else begin
			sclk_prev_q <= sclk_s;
			ls_prev_q   <= ls_s;
		end
	end

	assign sclk_rise = sclk_s & ~sclk_prev_q;
	assign ls_rise   = ls_s & ~ls_prev_q;
	assign addr_w    = shift_q[15:8];
	assign code_w    = shift_q[7:0];

	// msb first, enters at bit 0 and walks up
	// window keeps the last 16 bits
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			shift_q <= 16'h0000;
		end else if (sclk_rise && !ls_s) begin
			shift_q <= {shift_q[14:0], din_s};
		end
	end

	// chain output carries the oldest bit
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			data_out <= 1'b0;
		end else if (sclk_rise && !ls_s) begin
			data_out <= shift_q[15];
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			ch1_code <= sacint_pkg::RESET_CODE;
			ch2_code <= sacint_pkg::RESET_CODE;
			ch3_code <= sacint_pkg::RESET_CODE;
			ch_mute  <= 3'h7;
		end else if (ls_rise) begin
			case (addr_w)
				sacint_pkg::ADDR_CH1: begin
					ch1_code   <= code_w;
					ch_mute[0] <= code_w >= sacint_pkg::CODE_MUTE_MIN;
				end
				sacint_pkg::ADDR_CH2: begin
					ch2_code   <= code_w;
					ch_mute[1] <= code_w >= sacint_pkg::CODE_MUTE_MIN;
				end
				sacint_pkg::ADDR_CH3: begin
					ch3_code   <= code_w;
					ch_mute[2] <= code_w >= sacint_pkg::CODE_MUTE_MIN;
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			ch1_halfdb <= sacint_pkg::RESET_HALFDB;
			ch2_halfdb <= sacint_pkg::RESET_HALFDB;
			ch3_halfdb <= sacint_pkg::RESET_HALFDB;
		end else if (ls_rise) begin
			if (addr_w == sacint_pkg::ADDR_CH1)
				ch1_halfdb <= code_to_halfdb(code_w);
			if (addr_w == sacint_pkg::ADDR_CH2)
				ch2_halfdb <= code_to_halfdb(code_w);
			if (addr_w == sacint_pkg::ADDR_CH3)
				ch3_halfdb <= code_to_halfdb(code_w);
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			frame_taken <= 1'b0;
		end else begin
			frame_taken <= ls_rise;
		end
	end

	property p_latch_ch1;
		@(posedge ref_clk) disable iff (!reset_n)
		(ls_rise && addr_w == sacint_pkg::ADDR_CH1) |=> (ch1_code == $past(code_w));
	endproperty
	a_latch_ch1: assert property (p_latch_ch1) else $error("ch1 not latched");

	property p_bad_addr;
		@(posedge ref_clk) disable iff (!reset_n)
		(ls_rise && addr_w > sacint_pkg::ADDR_CH3) |=> $stable(ch1_code) && $stable(ch2_code)
			&& $stable(ch3_code);
	endproperty
	a_bad_addr: assert property (p_bad_addr) else $error("bad address changed a channel");

	property p_hold_others;
		@(posedge ref_clk) disable iff (!reset_n)
		(ls_rise && addr_w == sacint_pkg::ADDR_CH2) |=> $stable(ch1_code) && $stable(ch3_code);
	endproperty
	a_hold_others: assert property (p_hold_others) else $error("unaddressed channel moved");

	property p_ch3_decode;
		@(posedge ref_clk) disable iff (!reset_n)
		(ls_rise && addr_w == sacint_pkg::ADDR_CH3) |=> (ch3_code == $past(code_w));
	endproperty
	a_ch3_decode: assert property (p_ch3_decode) else $error("ch3 decode wrong");

	property p_mute_flag;
		@(posedge ref_clk) disable iff (!reset_n)
		ch_mute[0] == (ch1_code >= sacint_pkg::CODE_MUTE_MIN);
	endproperty
	a_mute_flag: assert property (p_mute_flag) else $error("mute flag mismatch");

	property p_halfdb_mid;
		@(posedge ref_clk) disable iff (!reset_n)
		(ch2_code == 8'h20) |-> (ch2_halfdb == 10'h020);
	endproperty
	a_halfdb_mid: assert property (p_halfdb_mid) else $error("16 dB step wrong");

	property p_halfdb_top;
		@(posedge ref_clk) disable iff (!reset_n)
		(ch3_code == 8'h4E) |-> (ch3_halfdb == 10'h098);
	endproperty
	a_halfdb_top: assert property (p_halfdb_top) else $error("76 dB step wrong");

	property p_no_shift_high;
		@(posedge ref_clk) disable iff (!reset_n)
		ls_s |=> $stable(shift_q);
	endproperty
	a_no_shift_high: assert property (p_no_shift_high) else $error("shift while idle");

	property p_chain_out;
		@(posedge ref_clk) disable iff (!reset_n)
		(sclk_rise && !ls_s) |=> (data_out == $past(shift_q[15]));
	endproperty
	a_chain_out: assert property (p_chain_out) else $error("chain output wrong");
endmodule
`default_nettype wire

// File: testbench/sacint_host.sv
// host model driving the three serial pins
`timescale 1ns/1ps
`default_nettype none
module sacint_host (
	input  wire logic        ref_clk,
	input  wire logic        data_out,
	output var  logic        sclk,
	output var  logic        load_shift,
	output var  logic        data_in,
	output var  logic [31:0] seen
);
	initial begin
		sclk = 1'b0;
		load_shift = 1'b1;
		data_in = 1'b0;
		seen = '0;
	end
	task automatic step(input int k);
		repeat (k) @(posedge ref_clk);
		#1;
	endtask
	// one serial clock per bit; stray also pulses the clock outside frames, with enable high
	task automatic pulse();
		step(4);
		sclk = 1'b1;
		step(4);
		sclk = 1'b0;
		step(2);
	endtask
	// enable low early, held over all bits
	task automatic send(input logic [31:0] v, input int n);
		load_shift = 1'b0;
		step(7);
		for (int i = n - 1; i >= 0; i--) begin
			data_in = v[i];
			pulse();
			seen = {seen[30:0], data_out};
		end
		step(4);
		load_shift = 1'b1;
		// released data line must not keep looking valid
		data_in = ~data_in;
	endtask
	task automatic stray(input int n);
		data_in = 1'b1;
		repeat (n) pulse();
	endtask
endmodule
`default_nettype wire

// File: testbench/sacint_top_tb.sv
// self-checking bench for the attenuator serial control
`timescale 1ns/1ps
`default_nettype none
module sacint_top_tb;
	logic        ref_clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        sclk, load_shift, data_in, data_out, frame_taken;
	logic [7:0]  c1, c2, c3;
	logic [2:0]  mute;
	logic [9:0]  h1, h2, h3;
	logic [31:0] seen;
	int          fail_count = 0;
	int          checked = 0;
	int          cycles = 0;
	always #12.5 ref_clk = ~ref_clk;
	sacint_top DUT (.ref_clk(ref_clk), .reset_n(reset_n), .sclk(sclk),
		.load_shift(load_shift), .data_in(data_in), .data_out(data_out),
		.ch1_code(c1), .ch2_code(c2), .ch3_code(c3), .ch_mute(mute),
		.ch1_halfdb(h1), .ch2_halfdb(h2), .ch3_halfdb(h3), .frame_taken(frame_taken));
	sacint_host host (.ref_clk(ref_clk), .data_out(data_out), .sclk(sclk),
		.load_shift(load_shift), .data_in(data_in), .seen(seen));
	task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic complete_run();
		if (fail_count == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic frame(input logic [31:0] v, input int n);
		int k = 0;
		host.send(v, n);
		while (frame_taken !== 1'b1 && k < 20) begin
			host.step(1);
			k++;
		end
		check("frame_taken", frame_taken, 1'b1);
		host.step(2);
	endtask
	task automatic state(input logic [7:0] e1, e2, e3, input logic [9:0] g1, g2, g3,
		input logic [2:0] m);
		check("ch1_code", c1, e1);
		check("ch2_code", c2, e2);
		check("ch3_code", c3, e3);
		check("ch1_halfdb", h1, g1);
		check("ch2_halfdb", h2, g2);
		check("ch3_halfdb", h3, g3);
		check("ch_mute", mute, m);
	endtask
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			complete_run();
		end
	end
	initial begin
		repeat (8) @(posedge ref_clk);
		#1;
		reset_n = 1'b1;
		host.step(3);
		state(8'hFF, 8'hFF, 8'hFF, 10'h3FF, 10'h3FF, 10'h3FF, 3'b111);
		// top of half-dB, bottom of one-dB, top of two-dB range and first mute code, one channel at a time
		frame({16'h0, sacint_pkg::ADDR_CH1, 8'h1F}, 16);
		state(8'h1F, 8'hFF, 8'hFF, 10'h01F, 10'h3FF, 10'h3FF, 3'b110);
		frame({16'h0, sacint_pkg::ADDR_CH2, 8'h20}, 16);
		state(8'h1F, 8'h20, 8'hFF, 10'h01F, 10'h020, 10'h3FF, 3'b100);
		frame({16'h0, sacint_pkg::ADDR_CH3, 8'h4E}, 16);
		state(8'h1F, 8'h20, 8'h4E, 10'h01F, 10'h020, 10'h098, 3'b000);
		frame({16'h0, sacint_pkg::ADDR_CH2, 8'h4F}, 16);
		state(8'h1F, 8'h4F, 8'h4E, 10'h01F, 10'h3FF, 10'h098, 3'b010);
		frame({16'h0, 8'h03, 8'h00}, 16);
		state(8'h1F, 8'h4F, 8'h4E, 10'h01F, 10'h3FF, 10'h098, 3'b010);
		// two frames under one enable: last one is latched, first passes on
		frame({sacint_pkg::ADDR_CH1, 8'h05, sacint_pkg::ADDR_CH3, 8'h40}, 32);
		check("chain_out", seen, 32'h0300_0005);
		state(8'h1F, 8'h4F, 8'h40, 10'h01F, 10'h3FF, 10'h060, 3'b010);
		host.stray(3);
		frame({16'h0, sacint_pkg::ADDR_CH1, 8'h00}, 16);
		check("chain_out", seen[15:0], 16'h0240);
		state(8'h00, 8'h4F, 8'h40, 10'h000, 10'h3FF, 10'h060, 3'b010);
		// reset in mid-run mutes every channel again
		reset_n = 1'b0;
		host.step(2);
		reset_n = 1'b1;
		host.step(3);
		state(8'hFF, 8'hFF, 8'hFF, 10'h3FF, 10'h3FF, 10'h3FF, 3'b111);
		complete_run();
	end
endmodule
`default_nettype wire
